/* src/bstc_pkg.sv */
// Constants, state codes and timing of the bus-state trace capture unit
package bstc_pkg;
  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int STATE_W = 32;
  localparam int NTERM = 4;
  localparam int TIDX_W = 2;
  localparam int TERM_W = 3;
  localparam int OCC_W = 16;
  localparam int MEM_DEPTH = 1024;
  localparam int ADDR_W = 10;
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] CAP_NOCOUNT = 11'h400;
  localparam logic [CNT_W-1:0] CAP_COUNT = 11'h200;
  localparam logic [CNT_W-1:0] MIN_DEPTH = 11'h009;
  localparam logic [TERM_W-1:0] NTERM_T = 3'h4;
  // ----------------------------------------------------------------
  // Values after reset: one term, one occurrence, any state
  // ----------------------------------------------------------------
  localparam logic [STATE_W-1:0] VAL_RESET = 32'h0;
  localparam logic [STATE_W-1:0] MASK_RESET = 32'h0;
  localparam logic [OCC_W-1:0] OCC_RESET = 16'h0001;
  localparam logic [TERM_W-1:0] LAST_RESET = 3'h0;
  localparam logic [CNT_W-1:0] STORED_RESET = 11'h000;
  // ----------------------------------------------------------------
  // Arm-to-trigger timing
  // ----------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real ATR_MAX_MS = 41.943;
  localparam real ATR_MIN_US = -0.04;
  localparam int ATR_MAX_CYC =
    $rtoi(ATR_MAX_MS * 1.0e6 / CLK_PERIOD_NS + 1.0e-6);
  localparam int ATR_NEG_CYC =
    $rtoi(-ATR_MIN_US * 1.0e3 / CLK_PERIOD_NS + 1.0e-6);
  localparam int ATR_W = 23;
  // ----------------------------------------------------------------
  // Status codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ARM_IGNORED = 2'h0;
  localparam logic [1:0] ARM_NOT_RCVD = 2'h1;
  localparam logic [1:0] ARM_RCVD = 2'h2;
  typedef enum logic [1:0] {MS_IDLE, MS_RUN, MS_COMPLETE, MS_HALT}
    bstc_meas_t;
endpackage

/* src/bstc_trace_mem.sv */
// Trace memory with one write port and a registered read port
`timescale 1ns/10ps
module bstc_trace_mem
  import bstc_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [STATE_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [STATE_W-1:0] rd_data_reg
);
  logic [STATE_W-1:0] mem [MEM_DEPTH];

  // No reset on the array so it maps onto block RAM
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rd_en)
    begin
      rd_data_reg <= mem[rd_addr];
    end
  end
endmodule

/* src/bstc_top.sv */
// Bus-state trace capture: sampling, sequencer, storage and status
`timescale 1ns/10ps
// Notes on behaviour
// R1 - Sample bus every clock while running
// R2 - Store after trigger; complete when memory full
// R3 - Default spec matches any state
// R4 - Default setup stores every cycle until full
// R5 - Depth 1024, or 512 with counting
// R6 - Trigger state stored at line zero
// R7 - Stop request halts storing at once
// R8 - Report running, complete or halted
// R9 - Arm status ignored, not received, received
// R10 - Arm latch catches arms after halt too
// R11 - Measure arm to trigger, flag range
// R12 - Report stored, possible and last line
// R13 - Trigger leaves last term; term past it
// R14 - Halted term holds pre-halt value
// R15 - Readable occurrence down-count per term
// R16 - Newest state unreadable until run ends
// R17 - Trace depth never below nine states
// R18 - Start clears count, arm, term; reloads
module bstc_top
  import bstc_pkg::*;
#(
  parameter int ATR_MAX = ATR_MAX_CYC
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [STATE_W-1:0] bus_in,
  input wire logic arm_in,
  input wire logic meas_start,
  input wire logic meas_stop,
  input wire logic count_on,
  input wire logic arm_internal,
  input wire logic spec_load,
  input wire logic [NTERM*STATE_W-1:0] spec_val_in,
  input wire logic [NTERM*STATE_W-1:0] spec_mask_in,
  input wire logic [NTERM*OCC_W-1:0] spec_occ_in,
  input wire logic [TERM_W-1:0] spec_last_in,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [STATE_W-1:0] rd_data,
  output logic rd_valid,
  output logic meas_running,
  output logic meas_complete,
  output logic meas_halted,
  output logic [1:0] arm_status,
  output logic [CNT_W-1:0] states_stored,
  output logic [CNT_W-1:0] states_possible,
  output logic [CNT_W-1:0] line_last,
  output logic [TERM_W-1:0] seq_term,
  output logic [OCC_W-1:0] occ_left,
  output logic atr_valid,
  output logic atr_negative,
  output logic atr_under,
  output logic atr_over,
  output logic [ATR_W-1:0] atr_cycles
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [ATR_W-1:0] ATR_LIM = ATR_W'(ATR_MAX);
  localparam logic [ATR_W-1:0] ATR_SAT = ATR_W'(ATR_MAX + 1);
  localparam logic [ATR_W-1:0] ATR_NEG = ATR_W'(ATR_NEG_CYC);

  bstc_meas_t st_reg, st_next;
  logic [STATE_W-1:0] bus_s1_reg, bus_s2_reg;
  logic arm_s1_reg, arm_s2_reg, arm_s3_reg;
  logic [TERM_W-1:0] term_reg, last_reg;
  logic [OCC_W-1:0] occ_reg;
  logic trig_seen_reg, arm_lat_reg, arm_mode_reg;
  logic [CNT_W-1:0] stored_reg, cap_reg, last_line_reg;
  logic [1:0] arm_stat_reg;
  logic running_reg, complete_reg, halted_reg, rd_valid_reg;
  logic [ATR_W-1:0] atr_cnt_reg, atr_out_reg;
  logic atr_neg_reg, atr_valid_reg, atr_under_reg, atr_over_reg;
  logic [NTERM-1:0] term_hit;
  logic [OCC_W-1:0] occ_tab [NTERM];

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    bus_s1_reg <= bus_in;
    bus_s2_reg <= bus_s1_reg;
    arm_s1_reg <= arm_in;
    arm_s2_reg <= arm_s1_reg;
    arm_s3_reg <= arm_s2_reg;
  end

  // ----------------------------------------------------------------
  // Trigger specification, one entry per sequencer term
  // ----------------------------------------------------------------
  // Loads are ignored while running so a term cannot change mid-match
  for (genvar gi = 0; gi < NTERM; gi++)
  begin : g_term
    logic [STATE_W-1:0] val_reg, mask_reg;
    logic [OCC_W-1:0] occ_spec_reg;
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        val_reg <= VAL_RESET; // [R3]
        mask_reg <= MASK_RESET; // [R3]
        occ_spec_reg <= OCC_RESET;
      end
      else if (spec_load && st_reg != MS_RUN)
      begin
        val_reg <= spec_val_in[gi*STATE_W +: STATE_W];
        mask_reg <= spec_mask_in[gi*STATE_W +: STATE_W];
        occ_spec_reg <= spec_occ_in[gi*OCC_W +: OCC_W];
      end
    end
    assign term_hit[gi] = ((bus_s2_reg ^ val_reg) & mask_reg) == '0;
    assign occ_tab[gi] = occ_spec_reg;
  end

  // ----------------------------------------------------------------
  // Sequencer and storage decode
  // ----------------------------------------------------------------
  wire run_ok = st_reg == MS_RUN && !meas_stop && !meas_start; // [R7]
  wire term_in = term_reg < NTERM_T;
  wire cur_hit = term_in && term_hit[term_reg[TIDX_W-1:0]];
  wire seq_adv = run_ok && !trig_seen_reg && cur_hit; // [R1]
  wire occ_one = occ_reg <= OCC_RESET;
  wire [TERM_W-1:0] term_inc = term_reg + 3'h1;
  wire trig_now = seq_adv && occ_one && term_reg == last_reg; // [R13]
  wire [OCC_W-1:0] occ_nxt_term =
    term_inc < NTERM_T ? occ_tab[term_inc[TIDX_W-1:0]] : OCC_RESET;
  wire wr_en = run_ok && (trig_now || trig_seen_reg); // [R2] [R4]
  wire [ADDR_W-1:0] wr_addr = stored_reg[ADDR_W-1:0]; // [R6]
  wire [CNT_W-1:0] stored_inc = stored_reg + 11'h001;
  wire full_now = wr_en && stored_inc == cap_reg; // [R2]
  wire arm_rise = arm_s2_reg && !arm_s3_reg;
  wire arm_now = arm_mode_reg && arm_rise;
  wire [CNT_W-1:0] readable =
    (st_reg == MS_RUN && stored_reg != '0) ? stored_reg - 11'h001
                                           : stored_reg; // [R16]
  wire rd_ok = {1'b0, rd_addr} < readable;
  wire [CNT_W-1:0] cap_sel = count_on ? CAP_COUNT : CAP_NOCOUNT; // [R5]
  wire atr_count = arm_lat_reg ^ trig_seen_reg;
  wire atr_ok = arm_mode_reg && arm_lat_reg && trig_seen_reg; // [R11]

  // ----------------------------------------------------------------
  // Measurement state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      MS_RUN:
      begin
        if (meas_start)
          st_next = MS_RUN;
        else if (meas_stop)
          st_next = MS_HALT; // [R7]
        else if (full_now)
          st_next = MS_COMPLETE; // [R2]
      end
      MS_IDLE, MS_COMPLETE, MS_HALT:
      begin
        if (meas_start)
          st_next = MS_RUN;
      end
      default:
        st_next = MS_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_reg <= MS_IDLE;
      running_reg <= 1'b0;
      complete_reg <= 1'b0;
      halted_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      running_reg <= st_next == MS_RUN; // [R8]
      complete_reg <= st_next == MS_COMPLETE; // [R8]
      halted_reg <= st_next == MS_HALT; // [R8]
    end
  end

  // ----------------------------------------------------------------
  // Sequencer position, occurrences and store count
  // ----------------------------------------------------------------
  // A halt freezes term and count, so the pre-halt term stays shown
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      term_reg <= '0;
      occ_reg <= OCC_RESET;
      last_reg <= LAST_RESET;
      trig_seen_reg <= 1'b0;
      stored_reg <= STORED_RESET;
      cap_reg <= CAP_NOCOUNT;
      arm_mode_reg <= 1'b0;
    end
    else if (meas_start)
    begin
      term_reg <= '0; // [R18]
      occ_reg <= occ_tab[0]; // [R18]
      last_reg <= spec_last_in;
      trig_seen_reg <= 1'b0;
      stored_reg <= STORED_RESET; // [R18]
      cap_reg <= cap_sel; // [R5]
      arm_mode_reg <= arm_internal;
    end
    else
    begin
      if (trig_now)
      begin
        term_reg <= term_inc; // [R13]
        trig_seen_reg <= 1'b1;
      end
      else if (seq_adv && occ_one)
      begin
        term_reg <= term_inc; // [R14]
        occ_reg <= occ_nxt_term; // [R15]
      end
      else if (seq_adv)
      begin
        occ_reg <= occ_reg - 16'h0001; // [R15]
      end
      if (wr_en)
        stored_reg <= stored_inc; // [R12]
    end
  end

  // ----------------------------------------------------------------
  // Arm latch and reported counts
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      arm_lat_reg <= 1'b0;
      arm_stat_reg <= ARM_IGNORED;
      last_line_reg <= STORED_RESET;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      // Arm wins over the clear of a start in the same cycle
      if (arm_now)
        arm_lat_reg <= 1'b1; // [R10]
      else if (meas_start)
        arm_lat_reg <= 1'b0; // [R18]
      arm_stat_reg <= !arm_mode_reg ? ARM_IGNORED
                    : arm_lat_reg ? ARM_RCVD : ARM_NOT_RCVD; // [R9]
      last_line_reg <= stored_reg == '0 ? '0
                     : stored_reg - 11'h001; // [R12]
      rd_valid_reg <= rd_en && rd_ok; // [R16]
    end
  end

  // ----------------------------------------------------------------
  // Arm-to-trigger timer
  // ----------------------------------------------------------------
  // Counts from whichever of arm and trigger comes first, saturating
  always_ff @(posedge clk)
  begin
    if (sys_rst || meas_start)
    begin
      atr_cnt_reg <= '0;
      atr_neg_reg <= 1'b0;
    end
    else
    begin
      if (atr_count && atr_cnt_reg != ATR_SAT)
        atr_cnt_reg <= atr_cnt_reg + 23'h000001; // [R11]
      if (trig_now && !arm_lat_reg && !arm_now)
        atr_neg_reg <= 1'b1; // [R11]
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      atr_valid_reg <= 1'b0;
      atr_under_reg <= 1'b0;
      atr_over_reg <= 1'b0;
      atr_out_reg <= '0;
    end
    else
    begin
      atr_valid_reg <= atr_ok; // [R11]
      atr_under_reg <= atr_ok && atr_neg_reg && atr_cnt_reg > ATR_NEG;
      atr_over_reg <= atr_ok && !atr_neg_reg && atr_cnt_reg > ATR_LIM;
      atr_out_reg <= atr_cnt_reg;
    end
  end

  // ----------------------------------------------------------------
  // Trace memory
  // ----------------------------------------------------------------
  bstc_trace_mem u_mem (
    .clk(clk),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(bus_s2_reg),
    .rd_en(rd_en && rd_ok),
    .rd_addr(rd_addr),
    .rd_data_reg(rd_data)
  );

  assign rd_valid = rd_valid_reg;
  assign meas_running = running_reg;
  assign meas_complete = complete_reg;
  assign meas_halted = halted_reg;
  assign arm_status = arm_stat_reg;
  assign states_stored = stored_reg;
  assign states_possible = cap_reg;
  assign line_last = last_line_reg;
  assign seq_term = term_reg;
  assign occ_left = occ_reg;
  assign atr_valid = atr_valid_reg;
  assign atr_negative = atr_neg_reg;
  assign atr_under = atr_under_reg;
  assign atr_over = atr_over_reg;
  assign atr_cycles = atr_out_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_stop_req;
    st_reg == MS_RUN && meas_stop && !meas_start;
  endsequence
  sequence s_halted;
    st_reg == MS_HALT && !wr_en && term_reg == $past(term_reg);
  endsequence

  a_sample_to_mem: assert property ( // [R1]
    wr_en |-> bus_s2_reg == $past(bus_in, 2))
    else $error("stored state is not the sampled bus");
  a_trig_at_zero: assert property ( // [R6]
    trig_now |-> wr_en && wr_addr == '0)
    else $error("trigger state not written to line zero");
  a_full_completes: assert property ( // [R2]
    (run_ok && wr_en && stored_inc == cap_reg)
      |=> st_reg == MS_COMPLETE ##1 meas_complete)
    else $error("full memory did not complete");
  a_depth_select: assert property ( // [R5]
    $past(meas_start) |-> cap_reg == ($past(count_on) ? 11'h200 : 11'h400))
    else $error("wrong capacity for counting option");
  a_min_depth: assert property ( // [R17]
    cap_reg >= MIN_DEPTH)
    else $error("trace depth below nine");
  a_stop_halts: assert property ( // [R7]
    s_stop_req |=> s_halted ##1 meas_halted)
    else $error("stop request did not halt");
  a_arm_latched: assert property ( // [R10]
    arm_now |=> arm_lat_reg ##1 arm_status == ARM_RCVD)
    else $error("arm event not latched");
  a_term_past_last: assert property ( // [R13]
    trig_now |=> term_reg == $past(last_reg) + 3'h1)
    else $error("term after trigger not one past last");
  a_occ_countdown: assert property ( // [R15]
    (seq_adv && !occ_one) |=> occ_reg == $past(occ_reg) - 16'h0001)
    else $error("occurrence count did not step down");
  a_newest_hidden: assert property ( // [R16]
    (st_reg == MS_RUN && rd_en && {1'b0, rd_addr} >= readable)
      |=> !rd_valid)
    else $error("newest state readable while running");
  a_start_clears: assert property ( // [R18]
    meas_start |=> stored_reg == '0 && term_reg == '0 && !trig_seen_reg)
    else $error("start did not clear measurement");
  a_atr_invalid: assert property ( // [R11]
    (!arm_mode_reg || !trig_seen_reg) |=> !atr_valid)
    else $error("arm to trigger valid without arm or trigger");
endmodule

/* verif/bstc_bus_model.sv */
// Model of the observed processor bus and its arm source
`timescale 1ns/10ps
module bstc_bus_model
  import bstc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [STATE_W-1:0] base,
  input wire logic arm_req,
  output logic [STATE_W-1:0] bus_in,
  output logic arm_in
);
  // ----------------------------------------------------------------
  // Bus states
  // ----------------------------------------------------------------
  // A counting bus makes every state unique for a long time, so the
  // bench can tell neighbouring stored lines apart and aim a trigger
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bus_in <= base;
      arm_in <= 1'b0;
    end
    else
    begin
      bus_in <= bus_in + 32'h1;
      arm_in <= arm_req;
    end
  end
endmodule

/* verif/bstc_top_tb.sv */
// Self-checking bench of the bus-state trace capture unit
`timescale 1ns/10ps
module bstc_top_tb
  import bstc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, sys_rst, arm_req, arm_in, meas_start, meas_stop, count_on;
  logic arm_internal, spec_load, rd_en, rd_valid, meas_running;
  logic meas_complete, meas_halted, atr_valid, atr_negative;
  logic atr_under, atr_over;
  logic [STATE_W-1:0] bus_in, base, rd_data, d0, d1;
  logic [NTERM*STATE_W-1:0] spec_val_in, spec_mask_in;
  logic [NTERM*OCC_W-1:0] spec_occ_in;
  logic [TERM_W-1:0] spec_last_in, seq_term;
  logic [ADDR_W-1:0] rd_addr, a;
  logic [1:0] arm_status;
  logic [CNT_W-1:0] states_stored, states_possible, line_last;
  logic [OCC_W-1:0] occ_left;
  logic [ATR_W-1:0] atr_cycles;
  logic [31:0] cap;
  logic [7:0] r;
  logic v0, v1;
  int mismatches, total_checks;

  bstc_bus_model bus_u (.clk(clk), .sys_rst(sys_rst), .base(base),
    .arm_req(arm_req), .bus_in(bus_in), .arm_in(arm_in));

  // Short range limit keeps the over-range case within a few cycles
  bstc_top #(.ATR_MAX(20)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .bus_in(bus_in), .arm_in(arm_in), .meas_start(meas_start),
    .meas_stop(meas_stop), .count_on(count_on),
    .arm_internal(arm_internal), .spec_load(spec_load),
    .spec_val_in(spec_val_in), .spec_mask_in(spec_mask_in),
    .spec_occ_in(spec_occ_in), .spec_last_in(spec_last_in),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .meas_running(meas_running),
    .meas_complete(meas_complete), .meas_halted(meas_halted),
    .arm_status(arm_status), .states_stored(states_stored),
    .states_possible(states_possible), .line_last(line_last),
    .seq_term(seq_term), .occ_left(occ_left), .atr_valid(atr_valid),
    .atr_negative(atr_negative), .atr_under(atr_under),
    .atr_over(atr_over), .atr_cycles(atr_cycles));

  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Samples land one step after the edge, never racing its updates
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (meas_complete !== 1'b1 && meas_halted !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
    chk(n < lim, 1'b1);
  endtask

  task automatic set_spec(input logic [127:0] v, input logic [127:0] m,
    input logic [63:0] o, input logic [2:0] l);
    @(posedge clk);
    spec_val_in <= v;
    spec_mask_in <= m;
    spec_occ_in <= o;
    spec_last_in <= l;
    spec_load <= 1'b1;
    @(posedge clk);
    spec_load <= 1'b0;
  endtask

  task automatic start(input logic c, input logic am);
    @(posedge clk);
    count_on <= c;
    arm_internal <= am;
    meas_start <= 1'b1;
    @(posedge clk);
    meas_start <= 1'b0;
  endtask

  task automatic stop_run();
    @(posedge clk);
    meas_stop <= 1'b1;
    @(posedge clk);
    meas_stop <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] ad, output logic [31:0] d,
    output logic v);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= ad;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
    v = rd_valid;
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hEF8A));
    base = $urandom;
    {sys_rst, arm_req, meas_start, meas_stop, count_on} = 5'h10;
    {arm_internal, spec_load, rd_en} = 3'h0;
    rd_addr = 10'h0;
    spec_val_in = '0;
    spec_mask_in = '0;
    spec_occ_in = '0;
    spec_last_in = 3'h0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    tick(1);
    chk({meas_running, meas_complete, meas_halted}, 3'h0);
    chk(occ_left, OCC_RESET);
    // Default spec: any state triggers, both capacities
    for (int k = 0; k < 2; k++)
    begin
      cap = (k == 0) ? 32'h200 : 32'h400;
      start(k == 0, 1'b0);
      tick(2);
      chk(meas_running, 1'b1);
      wait_done(1200);
      // Line count is registered from the store count, one clock behind
      tick(1);
      chk(meas_complete, 1'b1);
      chk(meas_running, 1'b0);
      chk(states_stored, cap);
      chk(states_possible, cap);
      chk(states_possible >= MIN_DEPTH, 1'b1);
      chk(line_last, cap - 32'h1);
      chk(seq_term, 3'h1);
      chk(arm_status, ARM_IGNORED);
      chk(atr_valid, 1'b0);
      repeat (6)
      begin
        a = 10'($urandom % (cap - 32'h1));
        rd(a, d0, v0);
        rd(a + 10'h1, d1, v1);
        chk({v0, v1}, 2'h3);
        chk(d1 - d0, 32'h1);
      end
    end
    // Two terms: occurrences, term advance, trigger line, arm timing
    r = bus_in[7:0] + 8'h80;
    set_spec({64'h0, 24'h0, r, 32'h0}, {64'h0, 32'hFF, 32'hF},
      {32'h0, 16'h2, 16'h3}, 3'h1);
    start(1'b0, 1'b1);
    @(posedge clk);
    arm_req <= 1'b1;
    for (int n = 0; n < 200 && seq_term !== 3'h1; n++)
      tick(1);
    chk(seq_term, 3'h1);
    chk(occ_left, 16'h2);
    chk(arm_status, ARM_RCVD);
    // Nothing stored yet, so even line zero is refused while running
    rd(10'h0, d0, v0);
    chk(v0, 1'b0);
    wait_done(1700);
    chk(meas_complete, 1'b1);
    chk(seq_term, 3'h2);
    rd(10'h0, d0, v0);
    chk(d0[7:0], r);
    chk(atr_over, 1'b1);
    // Timer saturates one past the shortened range limit of 20
    chk(atr_cycles, 32'h15);
    // Unreachable trigger, then halt, then a late arm
    @(posedge clk);
    arm_req <= 1'b0;
    set_spec({96'h0, bus_in - 32'h10}, {96'h0, 32'hFFFFFFFF},
      64'h1, 3'h0);
    start(1'b0, 1'b1);
    tick(20);
    chk(arm_status, ARM_NOT_RCVD);
    chk(states_stored, 11'h0);
    chk({seq_term, occ_left}, 19'h1);
    stop_run();
    tick(3);
    chk({meas_running, meas_halted}, 2'h1);
    chk(seq_term, 3'h0);
    @(posedge clk);
    arm_req <= 1'b1;
    tick(10);
    chk(arm_status, ARM_RCVD);
    chk(atr_valid, 1'b0);
    // Trigger long before arm, restart clearing the arm latch
    set_spec(128'h0, 128'h0, 64'h1, 3'h0);
    start(1'b0, 1'b1);
    tick(5);
    chk(arm_status, ARM_NOT_RCVD);
    @(posedge clk);
    arm_req <= 1'b0;
    tick(30);
    @(posedge clk);
    arm_req <= 1'b1;
    tick(10);
    stop_run();
    // A second stop while halted must be ignored
    stop_run();
    tick(3);
    chk(meas_halted, 1'b1);
    chk(seq_term, 3'h1);
    chk({atr_valid, atr_negative, atr_under}, 3'h7);
    rd(line_last[9:0], d0, v0);
    chk(v0, 1'b1);
    rd(states_stored[9:0], d0, v0);
    chk(v0, 1'b0);
    report_and_stop();
  end
endmodule
